// >>> core/rsm_pkg.sv
// Package with register map, field layout and timing constants of the reset source manager
package rsm_pkg;

  // ---------------------------------------------------------------
  // Register offsets (printed offsets are all multiples of four)
  // ---------------------------------------------------------------
  localparam logic [1:0] CAUSE_IDX = 2'h0;
  localparam logic [1:0] SOFT_IDX = 2'h1;
  localparam logic [1:0] UNLOCK_IDX = 2'h2;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CAUSE_ADDR = {CAUSE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] SOFT_ADDR = {SOFT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR = {UNLOCK_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 4'hC;

  // ---------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------
  localparam int POWER_UP_BIT = 0;
  localparam int BROWNOUT_BIT = 1;
  localparam int PIN_BIT = 2;
  localparam int WATCHDOG_BIT = 3;
  localparam int SOFTWARE_BIT = 4;
  localparam int DEBUG_BIT = 5;
  localparam int NUM_CAUSES = 6;
  localparam int SOFT_TRIGGER_BIT = 0;
  localparam logic [7:0] IO_REGISTER_KEY = 8'hD8;
  localparam logic [5:0] CAUSE_RESET = 6'h01;
  localparam logic [2:0] BOD_LEVEL_MIN = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int UNLOCK_WINDOW_INSTR = 4;
  localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'(UNLOCK_WINDOW_INSTR);
  localparam int INIT_NS = 300;
  localparam int INIT_CYC = (INIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] INIT_CYC_W = 4'(INIT_CYC);
  localparam int SUT_STEP_US = 1000;
  localparam int SUT_STEP_CYC = SUT_STEP_US * (CLK_HZ / 1000000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsm_bus_t;

  typedef struct packed {
    logic pin_reset_en;
    logic bod_en;
    logic [2:0] bod_level;
    logic [2:0] startup_delay_setting;
    logic scan_at_startup;
  } rsm_cfg_t;

endpackage

// >>> core/rsm_reset_source_manager.sv
// Reset source manager: merges reset requests, sequences system reset, records cause
//
// Summary of operation
// - Manager always active; brownout and pin sources need enabling first
// - Reload configuration-backed registers after every reset
// - Record reset source in cause flags
// - Power-up source always on, holds reset
// - Supply-low reasserts reset with no delay
// - Brownout level from config, minimum when unused
// - Pin reset held while enabled pin low
// - Unserviced watchdog timeout issues reset
// - Soft trigger write starts full reset
// - Init phase; startup delay for supply sources
// - Init phase extended until memory scan done
// - Operates in active and all sleep modes
// - Unlocked-less protected writes are ignored
// - Soft reset register guarded by io key
// - Cause flags clear on one; power-up clears others
// - After power-up only power-up flag sets
// - Soft trigger always reads zero
`timescale 1ns/1ps
module rsm_reset_source_manager #(
  parameter int SUT_STEP_CYCLES = rsm_pkg::SUT_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire rsm_pkg::rsm_bus_t bus,
  output logic [7:0] rdata,
  input wire rsm_pkg::rsm_cfg_t cfg,
  input wire logic supply_low,
  input wire logic brownout_monitor_trip,
  input wire logic reset_pin_n,
  input wire logic watchdog_unit_timeout,
  input wire logic debug_port_link_reset,
  input wire logic scan_done,
  input wire logic sleep_active,
  output logic [2:0] brownout_monitor_level,
  output logic system_reset,
  output logic config_reload,
  output logic scan_start,
  output logic override_available,
  output logic override_settings_clear,
  output logic volatile_clear
);

  // ---------------------------------------------------------------
  // Phase overview
  // ---------------------------------------------------------------
  // Hold: some request still active
  // Init: fixed settle time, longer after supply causes
  // Scan: optional wait for memory check
  // Run: reset released, flags readable
  // Config reload pulses once on leaving hold
  // Sleep state never gates any part of this block
  // Any new request sends the sequencer back to hold

  // ---------------------------------------------------------------
  // Limits
  // ---------------------------------------------------------------
  // Pin and brownout inputs arrive already synchronised
  // Watchdog and debug requests may be single pulses
  // Startup delay counts in steps of SUT_STEP_CYCLES
  // Soft write with trigger low still closes window
  // Unlock window counts clock cycles, not instructions
  // Flags keep their value across non power-up resets
  // Timer override status follows power-up causes only

  // ---------------------------------------------------------------
  // Request merge
  // ---------------------------------------------------------------
  logic [rsm_pkg::NUM_CAUSES-1:0] req;
  logic any_req;
  logic supply_req;
  logic por_active;

  // Source requests gated by their enables; sleep state never gates them
  // Power-up request covers srst and supply low
  // Brownout and pin need their configuration enables
  // Watchdog and debug are always armed
  always_comb begin
    req = '0;
    req[rsm_pkg::POWER_UP_BIT] = supply_low | srst;
    req[rsm_pkg::BROWNOUT_BIT] = cfg.bod_en & brownout_monitor_trip;
    req[rsm_pkg::PIN_BIT] = cfg.pin_reset_en & ~reset_pin_n;
    req[rsm_pkg::WATCHDOG_BIT] = watchdog_unit_timeout;
    req[rsm_pkg::DEBUG_BIT] = debug_port_link_reset;
  end

  // Brownout level forced to minimum when unused
  assign brownout_monitor_level = cfg.bod_en ? cfg.bod_level : rsm_pkg::BOD_LEVEL_MIN;

  // ---------------------------------------------------------------
  // Unlock guard and soft trigger
  // ---------------------------------------------------------------
  logic [2:0] unlock_reg;
  logic [2:0] unlock_next;
  logic soft_req_reg;
  logic soft_req_next;
  logic soft_wr;

  assign soft_wr = bus.wr && bus.addr == rsm_pkg::SOFT_ADDR;

  // Key opens a short window; soft write outside it is dropped
  // A second key write restarts the window
  // Soft write consumes the window, hit or miss
  // Any reset closes the window at once
  // Key value only accepted at the unlock offset
  always_comb begin
    unlock_next = unlock_reg;
    soft_req_next = 1'b0;
    if (unlock_reg != 3'h0) begin
      unlock_next = unlock_reg - 3'h1;
    end
    if (bus.wr && bus.addr == rsm_pkg::UNLOCK_ADDR && bus.wdata == rsm_pkg::IO_REGISTER_KEY) begin
      unlock_next = rsm_pkg::UNLOCK_WINDOW_CYC;
    end
    if (soft_wr && unlock_reg != 3'h0) begin
      soft_req_next = bus.wdata[rsm_pkg::SOFT_TRIGGER_BIT];
      unlock_next = 3'h0;
    end
    if (system_reset) begin
      unlock_next = 3'h0;
      soft_req_next = 1'b0;
    end
  end

  // Registers only; clearing decided above
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unlock_reg <= 3'h0;
      soft_req_reg <= 1'b0;
    end else begin
      unlock_reg <= unlock_next;
      soft_req_reg <= soft_req_next;
    end
  end

  assign supply_req = req[rsm_pkg::POWER_UP_BIT] | req[rsm_pkg::BROWNOUT_BIT];
  assign any_req = (|req) | soft_req_reg;

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_HOLD, ST_INIT, ST_SCAN, ST_RUN} rsm_state_t;
  rsm_state_t state_reg;
  rsm_state_t state_next;
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic supply_seen_reg;
  logic supply_seen_next;
  logic por_seen_reg;
  logic por_seen_next;
  logic [23:0] init_len;

  // Base init time plus startup delay steps for supply causes
  // Product fits 24 bits for the largest setting
  always_comb begin
    init_len = 24'(rsm_pkg::INIT_CYC_W);
    if (supply_seen_reg) begin
      init_len = 24'(rsm_pkg::INIT_CYC_W) + 24'(cfg.startup_delay_setting) * 24'(SUT_STEP_CYCLES);
    end
  end

  // Hazard: a request mid-init restarts from hold
  // Counter width covers the largest startup setting
  // Supply and power-up memory cleared only in run
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    supply_seen_next = supply_seen_reg;
    por_seen_next = por_seen_reg;
    if (any_req) begin
      state_next = ST_HOLD;
      cnt_next = 24'h000000;
      supply_seen_next = supply_seen_reg | supply_req;
      por_seen_next = por_seen_reg | req[rsm_pkg::POWER_UP_BIT];
    end else begin
      unique case (state_reg)
        ST_HOLD: begin
          state_next = ST_INIT;
          cnt_next = 24'h000000;
        end
        ST_INIT: begin
          cnt_next = cnt_reg + 24'h000001;
          if (cnt_reg + 24'h000001 >= init_len) begin
            state_next = cfg.scan_at_startup ? ST_SCAN : ST_RUN;
          end
        end
        ST_SCAN: begin
          if (scan_done) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          // Forget the causes once running
          supply_seen_next = 1'b0;
          por_seen_next = 1'b0;
        end
      endcase
    end
  end

  // Power-up reset is applied by srst itself, so state takes a constant there
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_HOLD;
      cnt_reg <= 24'h000000;
      supply_seen_reg <= 1'b1;
      por_seen_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      supply_seen_reg <= supply_seen_next;
      por_seen_reg <= por_seen_next;
    end
  end

  // ---------------------------------------------------------------
  // Reset outputs
  // ---------------------------------------------------------------

  // Power-up sequence, live from the first request cycle
  assign por_active = req[rsm_pkg::POWER_UP_BIT] || (por_seen_reg && state_reg != ST_RUN);

  // Reset held through all phases before run
  assign system_reset = any_req || state_reg != ST_RUN;
  assign config_reload = state_reg == ST_HOLD && !any_req;
  assign scan_start = state_reg == ST_SCAN;
  assign volatile_clear = system_reset;
  assign override_settings_clear = por_active;
  assign override_available = !por_active;

  // ---------------------------------------------------------------
  // Reset cause flags
  // ---------------------------------------------------------------
  logic [rsm_pkg::NUM_CAUSES-1:0] cause_reg;
  logic [rsm_pkg::NUM_CAUSES-1:0] cause_next;
  logic [rsm_pkg::NUM_CAUSES-1:0] cause_set;

  // Set beats clear when both land in one cycle
  // Power-up forces flags to power-up only
  // Forcing lasts until run, per boot rule
  always_comb begin
    cause_set = req;
    cause_set[rsm_pkg::SOFTWARE_BIT] = soft_req_reg;
    cause_next = cause_reg;
    if (bus.wr && bus.addr == rsm_pkg::CAUSE_ADDR) begin
      cause_next = cause_reg & ~bus.wdata[rsm_pkg::NUM_CAUSES-1:0];
    end
    if (por_active) begin
      cause_next = rsm_pkg::CAUSE_RESET;
    end else begin
      cause_next = cause_next | cause_set;
    end
  end

  // Power-up value on srst
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cause_reg <= rsm_pkg::CAUSE_RESET;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // ---------------------------------------------------------------
  // Read port, data one cycle after strobe
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;
  logic [7:0] config_view;

  // Status view: sleep state, scan, startup delay, brownout level
  assign config_view = {sleep_active, cfg.scan_at_startup, cfg.startup_delay_setting,
    cfg.bod_level};

  // Unmapped and write-only offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        rsm_pkg::CAUSE_ADDR: rdata_next = {2'h0, cause_reg};
        rsm_pkg::SOFT_ADDR: rdata_next = 8'h00;
        rsm_pkg::CONFIG_ADDR: rdata_next = config_view;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data register, cleared by reset too
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule // rsm_reset_source_manager

// >>> verif/rsm_far_side.sv
// Far-side model: supply monitors, reset pin, watchdog, debug link, memory scan
`timescale 1ns/1ps
module rsm_far_side (
  input wire logic ref_clk,
  input wire logic [4:0] req,
  input wire logic [3:0] lag,
  input wire logic scan_start,
  output logic supply_low,
  output logic brownout_monitor_trip,
  output logic reset_pin_n,
  output logic watchdog_unit_timeout,
  output logic debug_port_link_reset,
  output logic scan_done
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  // Request levels; a released pin returns high through its pull-up
  assign supply_low = req[0];
  assign brownout_monitor_trip = req[1];
  assign reset_pin_n = !req[2];
  assign watchdog_unit_timeout = req[3];
  assign debug_port_link_reset = req[4];
  // Scan reports done only after lag cycles of running
  assign scan_done = scan_start && (cnt_reg >= lag);
  always_comb begin
    cnt_next = scan_start ? cnt_reg + 4'h1 : 4'h0;
  end
  always_ff @(posedge ref_clk) begin
    cnt_reg <= cnt_next;
  end
endmodule // rsm_far_side

// >>> verif/rsm_reset_checker_properties.sv
// Concurrent checks on the reset source manager ports
`timescale 1ns/1ps
module rsm_reset_checker #(
  parameter int SUT_STEP_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire rsm_pkg::rsm_bus_t bus,
  input wire logic [7:0] rdata,
  input wire rsm_pkg::rsm_cfg_t cfg,
  input wire logic supply_low,
  input wire logic brownout_monitor_trip,
  input wire logic reset_pin_n,
  input wire logic watchdog_unit_timeout,
  input wire logic debug_port_link_reset,
  input wire logic scan_done,
  input wire logic sleep_active,
  input wire logic [2:0] brownout_monitor_level,
  input wire logic system_reset,
  input wire logic config_reload,
  input wire logic scan_start,
  input wire logic override_available,
  input wire logic override_settings_clear,
  input wire logic volatile_clear
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_supply_low: assert property (supply_low |-> system_reset && override_settings_clear)
    else $error("supply low without power-up reset");
  chk_bod_trip: assert property (brownout_monitor_trip && cfg.bod_en |-> system_reset)
    else $error("brownout trip without reset");
  chk_bod_level: assert property (brownout_monitor_level ==
    (cfg.bod_en ? cfg.bod_level : rsm_pkg::BOD_LEVEL_MIN))
    else $error("brownout level wrong");
  chk_pin_hold: assert property (!reset_pin_n && cfg.pin_reset_en |-> system_reset)
    else $error("pin low without reset");
  chk_wdt_req: assert property (watchdog_unit_timeout |-> system_reset)
    else $error("watchdog timeout without reset");
  chk_debug_req: assert property (debug_port_link_reset |-> system_reset)
    else $error("debug request without reset");
  chk_volatile_all: assert property (volatile_clear == system_reset)
    else $error("volatile clear differs from reset");
  chk_override_pair: assert property (override_available != override_settings_clear)
    else $error("override flags inconsistent");
  chk_init_hold: assert property (config_reload |=> system_reset [*6])
    else $error("init phase too short");
  chk_scan_wait: assert property (scan_start && !scan_done |-> system_reset)
    else $error("reset released before scan done");
  chk_soft_start: assert property ($past(bus.wr && bus.addr == rsm_pkg::UNLOCK_ADDR
    && bus.wdata == rsm_pkg::IO_REGISTER_KEY, 2) && bus.wr
    && bus.addr == rsm_pkg::SOFT_ADDR && bus.wdata[0] |=> system_reset)
    else $error("unlocked soft write gave no reset");
  chk_soft_zero: assert property ($past(bus.rd && bus.addr == rsm_pkg::SOFT_ADDR)
    |-> rdata == 8'h00)
    else $error("soft trigger read nonzero");
  // Main scenarios reached
  cover property (config_reload);
  cover property (scan_start && scan_done);
  cover property (!reset_pin_n && cfg.pin_reset_en);
endmodule // rsm_reset_checker
bind rsm_reset_source_manager rsm_reset_checker #(.SUT_STEP_CYCLES(SUT_STEP_CYCLES)) u_chk (.*);

// >>> verif/rsm_reset_source_manager_test.sv
// Self-checking bench for the reset source manager
`timescale 1ns/1ps
module rsm_reset_source_manager_test;
  localparam int STARTUP_DELAY_SETTING = 4;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  rsm_pkg::rsm_bus_t bus = '0;
  rsm_pkg::rsm_cfg_t cfg = 9'h002; // Startup delay setting 1
  logic sleep_active = 1'b0;
  logic [4:0] req = '0;
  logic [3:0] lag = 4'h5;
  logic [7:0] rdata;
  logic [2:0] brownout_monitor_level;
  logic supply_low, brownout_monitor_trip, reset_pin_n, watchdog_unit_timeout;
  logic debug_port_link_reset, scan_done, system_reset, config_reload, scan_start;
  logic override_available, override_settings_clear, volatile_clear;
  int fail_count = 0;
  int n_tests = 0;
  integer seed = 35;
  int sut_now = 1;
  int n;
  int i;
  bit en;
  rsm_reset_source_manager #(.SUT_STEP_CYCLES(STARTUP_DELAY_SETTING)) dut (.*);
  rsm_far_side u_far (.*);
  always #25 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic int exp_tail(input bit supply);
    return 1 + rsm_pkg::INIT_CYC + (supply ? sut_now * STARTUP_DELAY_SETTING : 0);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, exp);
  endtask
  task automatic tail(output int cnt);
    cnt = 0;
    @(negedge ref_clk);
    while (system_reset === 1'b1 && cnt < 300) begin
      cnt++;
      @(negedge ref_clk);
    end
  endtask
  task automatic pulse(input int src, input bit exp);
    @(posedge ref_clk);
    req <= 5'(1 << src);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({7'h0, system_reset}, {7'h0, exp});
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic results();
    $display("tests %0d, fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk({6'h0, override_available, override_settings_clear}, 8'h01);
    tail(n);
    chk(8'(n), 8'(exp_tail(1) - 1));
    chk({6'h0, override_available, override_settings_clear}, 8'h02);
    rd(rsm_pkg::CAUSE_ADDR, 8'h01);
    for (int j = 0; j < 7; j++) begin
      i = (j < 2) ? j + 1 : j - 2;
      en = (j >= 2);
      wr(rsm_pkg::CAUSE_ADDR, 8'h3F);
      rd(rsm_pkg::CAUSE_ADDR, 8'h00);
      sut_now = $unsigned($random(seed)) % 4;
      @(posedge ref_clk);
      cfg <= '{pin_reset_en: en, bod_en: en, bod_level: 3'($random(seed)),
        startup_delay_setting: 3'(sut_now), scan_at_startup: 1'b0};
      sleep_active <= 1'($random(seed));
      @(negedge ref_clk);
      chk(8'(brownout_monitor_level), en ? 8'(cfg.bod_level) : 8'h00);
      pulse(i, en || i == 0 || i > 2);
      tail(n);
      chk(8'(n), en ? 8'(exp_tail(i < 2)) : 8'h00);
      rd(rsm_pkg::CAUSE_ADDR, en ? 8'(1 << (i == 4 ? 5 : i)) : 8'h00);
    end
    wr(rsm_pkg::CAUSE_ADDR, 8'h3F);
    wr(rsm_pkg::SOFT_ADDR, 8'h01);
    rd(rsm_pkg::CAUSE_ADDR, 8'h00);
    wr(rsm_pkg::UNLOCK_ADDR, rsm_pkg::IO_REGISTER_KEY);
    repeat (6) @(posedge ref_clk);
    wr(rsm_pkg::SOFT_ADDR, 8'h01);
    rd(rsm_pkg::CAUSE_ADDR, 8'h00);
    wr(rsm_pkg::UNLOCK_ADDR, rsm_pkg::IO_REGISTER_KEY);
    wr(rsm_pkg::SOFT_ADDR, 8'h01);
    tail(n);
    chk(8'(n), 8'(exp_tail(0) + 1));
    rd(rsm_pkg::CAUSE_ADDR, 8'h10);
    rd(rsm_pkg::SOFT_ADDR, 8'h00);
    rd(4'h1, 8'h00);
    cfg.scan_at_startup <= 1'b1;
    wr(rsm_pkg::UNLOCK_ADDR, rsm_pkg::IO_REGISTER_KEY);
    wr(rsm_pkg::SOFT_ADDR, 8'h01);
    tail(n);
    chk(8'(n), 8'(exp_tail(0) + 2 + lag));
    results();
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    results();
  end
endmodule // rsm_reset_source_manager_test
